// File: core/uiav_pkg.sv
package uiav_pkg;

   // ----------------------------------------------------------------
   // register map (word index on the plain register port)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_PENDING = 4'h0;
   localparam logic [3:0] ADDR_ENABLE = 4'h1;
   localparam logic [3:0] ADDR_SETUP = 4'h2;
   localparam logic [3:0] ADDR_VECTOR = 4'h3;
   localparam logic [3:0] ADDR_ERR_LIMIT = 4'h4;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int SETUP_AV_EN_BIT = 0;
   localparam int VECTOR_IRQ_BIT = 8;
   localparam int ERR_COUNT_LSB = 8;
   localparam logic [31:0] PENDING_RESET = 32'h0000_0000;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic SETUP_AV_EN_RESET = 1'b0;
   localparam logic [7:0] VECTOR_RESET = 8'h00;

   // ----------------------------------------------------------------
   // source slots: slot number times four is the vector byte
   // ----------------------------------------------------------------
   localparam int NUM_SLOTS = 32;
   localparam logic [31:0] RESERVED_SLOTS = 32'h0e02_0080;
   localparam int SLOT_ERR_LIMIT = 24;

   // ----------------------------------------------------------------
   // interrupt entry fetch addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ENTRY_OPCODE_ADDR = 16'h0043;
   localparam logic [15:0] ENTRY_PAGE_ADDR = 16'h0044;
   localparam logic [15:0] ENTRY_LOW_ADDR = 16'h0045;

   typedef enum logic [1:0]
   {
      ENTRY_IDLE = 2'b00,
      ENTRY_OPCODE = 2'b01,
      ENTRY_PAGE = 2'b10,
      ENTRY_LOW = 2'b11
   } uiav_entry_type;

endpackage

// File: core/uiav_prio_enc.sv
`timescale 1ns/1ps

// lowest set bit wins; o_index is zero when nothing is set
module uiav_prio_enc
#(
   parameter int N = 32
)
(
   input wire logic [N-1:0] i_req,
   output logic o_any,
   output logic [$clog2(N)-1:0] o_index
);

   initial
   begin
      if (N < 2)
      begin
         $error("uiav_prio_enc needs at least two inputs");
      end
   end

   always_comb
   begin
      o_any = 1'b0;
      o_index = '0;
      for (int k = N - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            o_any = 1'b1;
            o_index = k[$clog2(N)-1:0];
         end
      end
   end

endmodule

// File: core/uiav_err_count.sv
`timescale 1ns/1ps

// counts bus errors, saturating; pulses once when the count passes the limit
module uiav_err_count
#(
   parameter int CNT_W = 4
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_err_pulse,
   input wire logic i_clear,
   input wire logic [CNT_W-1:0] i_limit,
   output logic [CNT_W-1:0] o_count,
   output logic o_limit_hit
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic hit_reg;

   initial
   begin
      if (CNT_W < 1 || CNT_W > 24)
      begin
         $error("uiav_err_count width out of range");
      end
   end

   always_comb
   begin
      count_next = count_reg;
      if (i_err_pulse && count_reg != {CNT_W{1'b1}})
      begin
         count_next = count_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || i_clear)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || i_clear)
      begin
         hit_reg <= 1'b0;
      end
      else
      begin
         hit_reg <= (count_next > i_limit) && (count_reg <= i_limit);
      end
   end

   assign o_count = count_reg;
   assign o_limit_hit = hit_reg;

endmodule

// File: core/uiav_top.sv
`timescale 1ns/1ps

module uiav_top
#(
   parameter int ERR_CNT_W = 4
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [31:0] i_src_event,
   input wire logic i_bus_error,
   input wire logic i_irq_taken,
   input wire logic i_fetch_stb,
   input wire logic [15:0] i_fetch_addr,
   input wire logic [7:0] i_fetch_data,
   output logic o_fetch_valid,
   output logic [7:0] o_fetch_data,
   output logic o_usb_shared_irq,
   output logic [7:0] o_usb_vector_byte,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   output logic [31:0] o_rd_data
);

   initial
   begin
      if (ERR_CNT_W < 1 || ERR_CNT_W > 8)
      begin
         $error("uiav_top error counter width must be 1 to 8");
      end
   end

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic [31:0] pending_reg;
   logic [31:0] pending_next;
   logic [31:0] enable_reg;
   logic autovector_enable;
   logic [ERR_CNT_W-1:0] bus_error_limit;
   logic [ERR_CNT_W-1:0] err_count;
   logic err_hit;
   logic [31:0] set_bits;
   logic [31:0] clr_bits;
   logic [31:0] active_next;
   logic any_next;
   logic [4:0] slot_next;
   logic irq_reg;
   logic [7:0] vector_reg;
   logic [7:0] entry_vector_reg;
   uiav_pkg::uiav_entry_type entry_reg;
   logic [7:0] fetch_data_reg;
   logic fetch_valid_reg;
   logic [31:0] rd_data_reg;
   logic wr_err_limit;

   // ----------------------------------------------------------------
   // bus error counting
   // ----------------------------------------------------------------
   assign wr_err_limit = i_wr_stb && i_addr == uiav_pkg::ADDR_ERR_LIMIT;

   uiav_err_count
   #(
      .CNT_W(ERR_CNT_W)
   )
   u_err_count
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_err_pulse(i_bus_error),
      .i_clear(wr_err_limit),
      .i_limit(bus_error_limit),
      .o_count(err_count),
      .o_limit_hit(err_hit)
   );

   // ----------------------------------------------------------------
   // pending flags: set wins over a write-one clear
   // ----------------------------------------------------------------
   always_comb
   begin
      set_bits = i_src_event & ~uiav_pkg::RESERVED_SLOTS;
      set_bits[uiav_pkg::SLOT_ERR_LIMIT] = err_hit;
      clr_bits = '0;
      if (i_wr_stb && i_addr == uiav_pkg::ADDR_PENDING)
      begin
         clr_bits = i_wr_data;
      end
      pending_next = (pending_reg & ~clr_bits) | set_bits;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         pending_reg <= uiav_pkg::PENDING_RESET;
      end
      else
      begin
         pending_reg <= pending_next;
      end
   end

   // ----------------------------------------------------------------
   // software controls
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         enable_reg <= uiav_pkg::ENABLE_RESET;
         autovector_enable <= uiav_pkg::SETUP_AV_EN_RESET;
         bus_error_limit <= '0;
      end
      else if (i_wr_stb)
      begin
         if (i_addr == uiav_pkg::ADDR_ENABLE)
         begin
            enable_reg <= i_wr_data & ~uiav_pkg::RESERVED_SLOTS;
         end
         if (i_addr == uiav_pkg::ADDR_SETUP)
         begin
            autovector_enable <= i_wr_data[uiav_pkg::SETUP_AV_EN_BIT];
         end
         if (wr_err_limit)
         begin
            bus_error_limit <= i_wr_data[ERR_CNT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // priority pick and vector byte
   // ----------------------------------------------------------------
   assign active_next = pending_next & enable_reg & ~uiav_pkg::RESERVED_SLOTS;

   uiav_prio_enc
   #(
      .N(uiav_pkg::NUM_SLOTS)
   )
   u_prio_enc
   (
      .i_req(active_next),
      .o_any(any_next),
      .o_index(slot_next)
   );

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         irq_reg <= 1'b0;
         vector_reg <= uiav_pkg::VECTOR_RESET;
      end
      else
      begin
         irq_reg <= any_next;
         vector_reg <= {1'b0, slot_next, 2'b00};
      end
   end

   // ----------------------------------------------------------------
   // interrupt entry tracking
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         entry_reg <= uiav_pkg::ENTRY_IDLE;
         entry_vector_reg <= uiav_pkg::VECTOR_RESET;
      end
      else if (i_irq_taken)
      begin
         entry_reg <= uiav_pkg::ENTRY_OPCODE;
         entry_vector_reg <= vector_reg;
      end
      else if (i_fetch_stb)
      begin
         unique case (entry_reg)
            uiav_pkg::ENTRY_IDLE:
            begin
               entry_reg <= uiav_pkg::ENTRY_IDLE;
            end
            uiav_pkg::ENTRY_OPCODE:
            begin
               entry_reg <= (i_fetch_addr == uiav_pkg::ENTRY_OPCODE_ADDR) ?
                  uiav_pkg::ENTRY_PAGE : uiav_pkg::ENTRY_IDLE;
            end
            uiav_pkg::ENTRY_PAGE:
            begin
               entry_reg <= (i_fetch_addr == uiav_pkg::ENTRY_PAGE_ADDR) ?
                  uiav_pkg::ENTRY_LOW : uiav_pkg::ENTRY_IDLE;
            end
            uiav_pkg::ENTRY_LOW:
            begin
               entry_reg <= uiav_pkg::ENTRY_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // fetch path: substitute the low jump byte
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         fetch_valid_reg <= 1'b0;
         fetch_data_reg <= 8'h00;
      end
      else
      begin
         fetch_valid_reg <= i_fetch_stb;
         if (i_fetch_stb)
         begin
            if (autovector_enable && entry_reg == uiav_pkg::ENTRY_LOW &&
                i_fetch_addr == uiav_pkg::ENTRY_LOW_ADDR)
            begin
               fetch_data_reg <= entry_vector_reg;
            end
            else
            begin
               fetch_data_reg <= i_fetch_data;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         rd_data_reg <= 32'h0000_0000;
      end
      else if (i_rd_stb)
      begin
         rd_data_reg <= 32'h0000_0000;
         unique case (i_addr)
            uiav_pkg::ADDR_PENDING: rd_data_reg <= pending_reg;
            uiav_pkg::ADDR_ENABLE: rd_data_reg <= enable_reg;
            uiav_pkg::ADDR_SETUP: rd_data_reg[uiav_pkg::SETUP_AV_EN_BIT] <= autovector_enable;
            uiav_pkg::ADDR_VECTOR:
            begin
               rd_data_reg[7:0] <= vector_reg;
               rd_data_reg[uiav_pkg::VECTOR_IRQ_BIT] <= irq_reg;
            end
            uiav_pkg::ADDR_ERR_LIMIT:
            begin
               rd_data_reg[ERR_CNT_W-1:0] <= bus_error_limit;
               rd_data_reg[uiav_pkg::ERR_COUNT_LSB +: ERR_CNT_W] <= err_count;
            end
            default: rd_data_reg <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rd_data_reg <= 32'h0000_0000;
      end
   end

   assign o_usb_shared_irq = irq_reg;
   assign o_usb_vector_byte = vector_reg;
   assign o_fetch_valid = fetch_valid_reg;
   assign o_fetch_data = fetch_data_reg;
   assign o_rd_data = rd_data_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [31:0] active_now;
   logic [4:0] vec_slot;
   assign active_now = pending_reg & enable_reg;
   assign vec_slot = vector_reg[6:2];

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   irq_raise_a: assert property (i_src_event[3] && enable_reg[3] |=> o_usb_shared_irq)
      else $error("enabled event did not raise the shared line");
   entry_walk_a: assert property (i_irq_taken ##1 (i_fetch_stb && i_fetch_addr == 16'h0043 && !i_irq_taken)
      |=> entry_reg == uiav_pkg::ENTRY_PAGE)
      else $error("opcode fetch did not advance the entry sequence");
   av_subst_a: assert property (autovector_enable && entry_reg == uiav_pkg::ENTRY_LOW && i_fetch_stb
      && i_fetch_addr == 16'h0045 && !i_irq_taken |=> o_fetch_valid && o_fetch_data == $past(entry_vector_reg))
      else $error("low jump byte not replaced by the vector");
   ctrl_vec_a: assert property (pending_reg == 0 && i_src_event == 32'h0000_0040 && enable_reg[6] && !err_hit
      |=> o_usb_vector_byte == 8'h18)
      else $error("control handshake vector wrong");
   ep0_vec_a: assert property (pending_reg == 0 && i_src_event == 32'h0000_0200 && enable_reg[9] && !err_hit
      |=> o_usb_vector_byte == 8'h24)
      else $error("endpoint 0 out vector wrong");
   ep8_vec_a: assert property (pending_reg == 0 && i_src_event == 32'h0000_8000 && enable_reg[15] && !err_hit
      |=> o_usb_vector_byte == 8'h3c)
      else $error("endpoint 8 buffer vector wrong");
   bulk_nak_a: assert property (pending_reg == 0 && i_src_event == 32'h0001_0000 && enable_reg[16] && !err_hit
      |=> o_usb_vector_byte == 8'h40)
      else $error("bulk in nak vector wrong");
   ping_vec_a: assert property (pending_reg == 0 && i_src_event == 32'h0080_0000 && enable_reg[23] && !err_hit
      |=> o_usb_vector_byte == 8'h5c)
      else $error("endpoint 8 ping vector wrong");
   err_vec_a: assert property (err_hit |=> pending_reg[24])
      else $error("error limit did not set its pending flag");
   iso_vec_a: assert property (pending_reg == 0 && i_src_event == 32'h8000_0000 && enable_reg[31] && !err_hit
      |=> o_usb_vector_byte == 8'h7c)
      else $error("endpoint 8 iso error vector wrong");
   lowest_wins_a: assert property (o_usb_shared_irq && $stable(active_now) && $past(o_usb_shared_irq)
      |-> active_now[vec_slot] && (active_now & ((32'h1 << vec_slot) - 32'h1)) == 0)
      else $error("presented vector is not the lowest pending");
   no_reserved_a: assert property (vector_reg[1:0] == 2'b00 && !uiav_pkg::RESERVED_SLOTS[vec_slot]
      && !(|(pending_reg & uiav_pkg::RESERVED_SLOTS)))
      else $error("reserved vector presented");
   pass_through_a: assert property (i_fetch_stb && !autovector_enable |=> o_fetch_data == $past(i_fetch_data))
      else $error("fetched byte changed while autovectoring off");

   entry_cover_c: cover property (i_irq_taken ##1 i_fetch_stb ##[1:4] i_fetch_stb ##[1:4] (i_fetch_stb
      && entry_reg == uiav_pkg::ENTRY_LOW && autovector_enable));
   multi_pend_c: cover property (o_usb_shared_irq && $countones(active_now) > 1);
   err_limit_c: cover property (err_hit);

endmodule

// File: tb/uiav_core_model.sv
`timescale 1ns/1ps

// core side of the interrupt entry: takes the shared irq, then fetches the jump
module uiav_core_model
#(
   parameter logic [7:0] PAGE_BYTE = 8'h1b,
   parameter logic [7:0] MEM_LOW = 8'h5a,
   parameter int GAP = 1
)
(
   input wire logic i_clk_sys,
   input wire logic i_go,
   input wire logic i_irq,
   input wire logic i_fetch_valid,
   input wire logic [7:0] i_fetch_data,
   output logic o_irq_taken,
   output logic o_fetch_stb,
   output logic [15:0] o_fetch_addr,
   output logic [7:0] o_code_byte,
   output logic [7:0] o_low_byte,
   output logic [7:0] o_done_count
);
   // ----------------------------------------------------------------
   // code memory at the entry: opcode, preloaded page, low byte
   // ----------------------------------------------------------------
   function automatic logic [7:0] code_at(input int i);
      if (i == 0)
      begin
         return 8'h02;
      end
      return (i == 1) ? PAGE_BYTE : MEM_LOW;
   endfunction

   initial
   begin
      o_irq_taken = 1'b0;
      o_fetch_stb = 1'b0;
      o_fetch_addr = 16'hffff;
      o_code_byte = 8'hff;
      o_low_byte = 8'h00;
      o_done_count = 8'h00;
      forever
      begin
         @(posedge i_clk_sys);
         if (i_go && i_irq)
         begin
            o_irq_taken <= 1'b1;
            @(posedge i_clk_sys);
            o_irq_taken <= 1'b0;
            for (int i = 0; i < 3; i++)
            begin
               o_fetch_stb <= 1'b1;
               o_fetch_addr <= 16'h0043 + 16'(i);
               o_code_byte <= code_at(i);
               @(posedge i_clk_sys);
               if (i == 2 || GAP > 0)
               begin
                  // released bus shows the inverse of its last value
                  o_fetch_stb <= 1'b0;
                  o_fetch_addr <= ~(16'h0043 + 16'(i));
                  o_code_byte <= ~code_at(i);
               end
               if (i < 2)
               begin
                  repeat (GAP) @(posedge i_clk_sys);
               end
            end
            #1;
            o_low_byte = i_fetch_valid ? i_fetch_data : 8'hee;
            o_done_count = o_done_count + 8'h01;
         end
      end
   end
endmodule

// File: tb/tb_usb_interrupt_autovector.sv
`timescale 1ns/1ps

module tb_usb_interrupt_autovector;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [31:0] src_event = 32'h0;
   logic bus_error = 1'b0;
   logic go = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wr_data = 32'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic irq_taken, fetch_stb, fetch_valid, irq;
   logic [15:0] fetch_addr;
   logic [7:0] code_byte, fetch_data, vec, low_byte, done_count;
   logic [31:0] rd_data, e;
   int bad_count = 0;
   int tests_run = 0;

   always #25 i_clk_sys = ~i_clk_sys;

   uiav_top uiav_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_src_event(src_event),
      .i_bus_error(bus_error), .i_irq_taken(irq_taken), .i_fetch_stb(fetch_stb),
      .i_fetch_addr(fetch_addr), .i_fetch_data(code_byte), .o_fetch_valid(fetch_valid),
      .o_fetch_data(fetch_data), .o_usb_shared_irq(irq), .o_usb_vector_byte(vec),
      .i_addr(addr), .i_wr_data(wr_data), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rd_data));

   uiav_core_model uiav_core_model_inst (.i_clk_sys(i_clk_sys), .i_go(go), .i_irq(irq),
      .i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data), .o_irq_taken(irq_taken),
      .o_fetch_stb(fetch_stb), .o_fetch_addr(fetch_addr), .o_code_byte(code_byte),
      .o_low_byte(low_byte), .o_done_count(done_count));

   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task check32(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge i_clk_sys);
      wr_stb <= 1'b0;
   endtask

   task rd_check(input string name, input logic [3:0] a, input logic [31:0] exp);
      @(posedge i_clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge i_clk_sys);
      rd_stb <= 1'b0;
      #1;
      check32(name, exp, rd_data);
   endtask

   task pulse(input logic [31:0] v, input logic err);
      @(posedge i_clk_sys);
      src_event <= v;
      bus_error <= err;
      @(posedge i_clk_sys);
      src_event <= 32'h0;
      bus_error <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
   endtask

   // one interrupt entry by the core model; checks the low byte it saw against exp
   task run_entry(input logic [7:0] exp);
      logic [7:0] n;
      n = done_count;
      @(posedge i_clk_sys);
      go <= 1'b1;
      @(posedge i_clk_sys);
      go <= 1'b0;
      for (int t = 0; t < 40 && done_count === n; t++)
         @(posedge i_clk_sys);
      if (done_count === n)
      begin
         bad_count++;
         $display("FAIL entry expected done seen timeout");
         finish_test();
      end
      check32("low byte", {24'h0, exp}, {24'h0, low_byte});
   endtask

   initial
   begin
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int a = 0; a < 6; a++)
         rd_check("reset value", 4'(a), 32'h0);
      $display("test reset done");

      reg_wr(uiav_pkg::ADDR_ENABLE, 32'hffff_ffff);
      rd_check("enable", uiav_pkg::ADDR_ENABLE, ~uiav_pkg::RESERVED_SLOTS);
      for (int k = 0; k < 32; k++)
      begin
         e = (uiav_pkg::RESERVED_SLOTS[k] || k == uiav_pkg::SLOT_ERR_LIMIT) ? 32'h0 : 32'h1 << k;
         pulse(32'h1 << k, 1'b0);
         rd_check("pending", uiav_pkg::ADDR_PENDING, e);
         rd_check("vector", uiav_pkg::ADDR_VECTOR, (e == 0) ? 32'h0 : 32'h100 | 32'(k * 4));
         check32("irq", {31'h0, e != 0}, {31'h0, irq});
         check32("vector port", (e == 0) ? 32'h0 : 32'(k * 4), {24'h0, vec});
         reg_wr(uiav_pkg::ADDR_PENDING, 32'h1 << k);
      end
      $display("test vector table done");

      reg_wr(uiav_pkg::ADDR_ENABLE, 32'hbfff_ffff);
      pulse(32'h4002_0000, 1'b0);
      rd_check("masked", uiav_pkg::ADDR_VECTOR, 32'h0);
      reg_wr(uiav_pkg::ADDR_ENABLE, 32'hffff_ffff);
      pulse(32'h0000_0200, 1'b0);
      rd_check("priority", uiav_pkg::ADDR_VECTOR, 32'h124);
      reg_wr(uiav_pkg::ADDR_PENDING, 32'h0000_0200);
      rd_check("next", uiav_pkg::ADDR_VECTOR, 32'h178);
      reg_wr(uiav_pkg::ADDR_PENDING, 32'h4000_0000);
      rd_check("cleared", uiav_pkg::ADDR_VECTOR, 32'h0);
      $display("test priority done");

      reg_wr(uiav_pkg::ADDR_ERR_LIMIT, 32'h2);
      pulse(32'h0, 1'b1);
      pulse(32'h0, 1'b1);
      rd_check("at limit", uiav_pkg::ADDR_VECTOR, 32'h0);
      pulse(32'h0, 1'b1);
      rd_check("past limit", uiav_pkg::ADDR_VECTOR, 32'h160);
      rd_check("err count", uiav_pkg::ADDR_ERR_LIMIT, 32'h302);
      reg_wr(uiav_pkg::ADDR_PENDING, 32'h0100_0000);
      $display("test error limit done");

      reg_wr(uiav_pkg::ADDR_SETUP, 32'h1);
      rd_check("setup", uiav_pkg::ADDR_SETUP, 32'h1);
      pulse(32'h20, 1'b0);
      run_entry(8'h14);
      reg_wr(uiav_pkg::ADDR_PENDING, 32'h20);
      reg_wr(uiav_pkg::ADDR_SETUP, 32'h0);
      pulse(32'h20, 1'b0);
      run_entry(8'h5a);
      reg_wr(uiav_pkg::ADDR_PENDING, 32'h20);
      $display("test autovector done");
      finish_test();
   end
endmodule
